// [verilog/port_pin_irq_mux.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pim_defines.svh"

module port_pin_irq_mux #(
  parameter int RC_DIV  = `RC_DIV,
  parameter int SAMPLES = `FILT_SAMPLES
) (
  input  wire logic       MCLK_I,
  input  wire logic       RST_I,
  input  wire logic [4:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output var  logic [7:0] RDATA_O,
  input  wire logic [7:0] PP_I,
  input  wire logic [7:0] PH_I,
  input  wire logic [6:0] PJ_I,
  output var  logic [7:0] PP_O,
  output var  logic [7:0] PP_OE_O,
  output var  logic [7:0] PH_O,
  output var  logic [7:0] PH_OE_O,
  output var  logic [6:0] PJ_O,
  output var  logic [6:0] PJ_OE_O,
  input  wire logic [7:0] SERIAL_DO_I,
  input  wire logic [7:0] SERIAL_OE_I,
  input  wire logic       TWI_EN_I,
  input  wire logic       TWI_SDA_LOW_I,
  input  wire logic       TWI_SCL_LOW_I,
  input  wire logic       STOP_I,
  input  wire logic       WAIT_I,
  input  wire logic [2:0] MODE_I,
  output var  logic       IRQ_P_O,
  output var  logic       IRQ_H_O,
  output var  logic       IRQ_J_O,
  output var  logic       IRQ_O,
  output var  logic       WAKE_O,
  output var  logic       RC_OSC_ON_O,
  output var  logic       EBUS_FUNC_O,
  output var  logic       EBUS_MUX_O
);

  localparam int NP = 24;
  localparam int RCW = $clog2(RC_DIV + 1);

  //--------------------------------------------------------------------
  // Storage
  //--------------------------------------------------------------------
  logic [NP-1:0]         data_ff;
  logic [NP-1:0]         dir_ff;
  logic [NP-1:0]         pol_ff;
  logic [NP-1:0]         ie_ff;
  logic [NP-1:0]         if_ff;
  logic [7:0]            route_ff;
  logic [NP-1:0]         sync1_ff;
  logic [NP-1:0]         sync2_ff;
  logic [2:0]            mode1_ff;
  logic [2:0]            mode2_ff;
  logic                  strap_done_ff;
  logic [1:0]            strap_vld_ff;
  pim_pkg::mode_e        mode_ff;
  logic [RCW-1:0]        rc_cnt_ff;
  logic                  rc_tick_ff;
  logic [NP-1:0]         nxt_if;
  logic [NP-1:0]         clr_if;
  logic [NP-1:0]         pending;
  logic                  osc_need;
  logic                  nxt_bus_func;
  logic [7:0]            nxt_rdata;

  pin_filter_if #(.W(NP)) fif ();

  // Slot index of a port register access, 3 when not a port slot
  function automatic logic [1:0] port_of(input logic [4:0] a);
    if (a[4:3] != 2'h3 && a[2:0] <= `REG_IF)
      port_of = a[4:3];
    else
      port_of = 2'h3;
  endfunction

  //--------------------------------------------------------------------
  // Pin synchronisers and mode strap capture
  //--------------------------------------------------------------------
  // Two-stage capture of all pin levels
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sync1_ff <= `RST_PINS;
      sync2_ff <= `RST_PINS;
    end
    else
    begin
      sync1_ff <= {1'b0, PJ_I, PH_I, PP_I};
      sync2_ff <= sync1_ff;
    end
  end

  // Mode pins synchronised then latched once after reset release
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mode1_ff      <= 3'h0;
      mode2_ff      <= 3'h0;
      strap_vld_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      mode_ff       <= pim_pkg::MODE_NORMAL_SC;
    end
    else
    begin
      mode1_ff <= MODE_I;
      mode2_ff <= mode1_ff;
      // Marks both sync stages as holding real pin samples
      strap_vld_ff <= {strap_vld_ff[0], 1'b1};
      // [RQ12] Latch sampled mode
      if (!strap_done_ff && strap_vld_ff[1] && mode2_ff == mode1_ff)
      begin
        strap_done_ff <= 1'b1;
        mode_ff       <= pim_pkg::mode_e'(mode2_ff);
      end
    end
  end

  //--------------------------------------------------------------------
  // Register writes
  //--------------------------------------------------------------------
  // Per-port data, direction, polarity and enable registers
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      data_ff  <= `RST_PINS;
      // [RQ11] Inputs after reset
      dir_ff   <= `RST_PINS;
      pol_ff   <= `RST_PINS;
      ie_ff    <= `RST_PINS;
      route_ff <= `RST_BYTE;
    end
    else if (WR_I)
    begin
      for (int p = 0; p < 3; p++)
      begin
        if (port_of(ADDR_I) == 2'(p))
        begin
          // [RQ1] Per-pin configuration
          if (ADDR_I[2:0] == `REG_DATA)
            data_ff[8*p +: 8] <= WDATA_I & 8'(`PIN_MASK >> (8*p));
          else if (ADDR_I[2:0] == `REG_DIR)
            dir_ff[8*p +: 8] <= WDATA_I & 8'(`PIN_MASK >> (8*p));
          else if (ADDR_I[2:0] == `REG_POL)
            pol_ff[8*p +: 8] <= WDATA_I & 8'(`PIN_MASK >> (8*p));
          else if (ADDR_I[2:0] == `REG_IE)
            ie_ff[8*p +: 8] <= WDATA_I & 8'(`PIN_MASK >> (8*p));
        end
      end
      if (ADDR_I == `ADDR_ROUTE)
        route_ff <= WDATA_I;
    end
  end

  //--------------------------------------------------------------------
  // Pin interrupt flags
  //--------------------------------------------------------------------
  // Write-one-to-clear mask from the flag register writes
  always_comb
  begin
    clr_if = '0;
    for (int p = 0; p < 3; p++)
      if (WR_I && port_of(ADDR_I) == 2'(p) && ADDR_I[2:0] == `REG_IF)
        clr_if[8*p +: 8] = WDATA_I;
    // [RQ17] Edge wins over clear
    nxt_if = ((if_ff & ~clr_if) | fif.valid_edge) & `PIN_MASK;
  end

  // [RQ3] Edges regardless of direction
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
      if_ff <= `RST_PINS;
    else
      if_ff <= nxt_if;
  end

  assign pending = if_ff & ie_ff;

  // Port requests, combined request and wake-up
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      IRQ_P_O <= 1'b0;
      IRQ_H_O <= 1'b0;
      IRQ_J_O <= 1'b0;
      IRQ_O   <= 1'b0;
      WAKE_O  <= 1'b0;
    end
    else
    begin
      // [RQ2] One request per port
      IRQ_P_O <= |pending[7:0];
      IRQ_H_O <= |pending[15:8];
      IRQ_J_O <= |pending[23:16];
      // [RQ4] Flag and enable
      IRQ_O   <= |pending;
      // [RQ5] Wake from stop or wait
      WAKE_O  <= (STOP_I || WAIT_I) && |pending;
    end
  end

  //--------------------------------------------------------------------
  // Filter clocking: bus clock or RC oscillator ticks
  //--------------------------------------------------------------------
  // [RQ9] Oscillator demand
  assign osc_need = |(fif.unsettled & ie_ff & ~if_ff & `PIN_MASK);

  // Divider standing in for the stop-mode RC oscillator
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rc_cnt_ff   <= '0;
      rc_tick_ff  <= 1'b0;
      RC_OSC_ON_O <= 1'b0;
    end
    else
    begin
      RC_OSC_ON_O <= STOP_I && osc_need;
      rc_tick_ff  <= 1'b0;
      // [RQ9] Oscillator gated
      if (!(STOP_I && osc_need))
        rc_cnt_ff <= '0;
      else if (rc_cnt_ff == RCW'(RC_DIV - 1))
      begin
        rc_cnt_ff  <= '0;
        rc_tick_ff <= 1'b1;
      end
      else
        rc_cnt_ff <= rc_cnt_ff + RCW'(1);
    end
  end

  // [RQ7] Bus clock sampling
  // [RQ8] RC tick in stop
  assign fif.sample_en = !STOP_I || rc_tick_ff;
  // [RQ10] Eight on H, seven on J
  assign fif.level     = sync2_ff & `PIN_MASK;
  assign fif.rising    = pol_ff;

  pin_edge_filter #(
    .W       (NP),
    .SAMPLES (SAMPLES)
  ) u_filter (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .fif   (fif)
  );

  //--------------------------------------------------------------------
  // Pin drivers
  //--------------------------------------------------------------------
  // Port outputs with routing and open-drain overrides
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      PP_O    <= 8'h00;
      PP_OE_O <= 8'h00;
      PH_O    <= 8'h00;
      PH_OE_O <= 8'h00;
      PJ_O    <= 7'h00;
      PJ_OE_O <= 7'h00;
    end
    else
    begin
      PP_O    <= data_ff[7:0];
      PP_OE_O <= dir_ff[7:0];
      PH_O    <= data_ff[15:8];
      PH_OE_O <= dir_ff[15:8];
      PJ_O    <= data_ff[22:16];
      PJ_OE_O <= dir_ff[22:16];
      // [RQ16] Serial routing onto H
      if (route_ff[`ROUTE_SER1_BIT])
      begin
        PH_O[3:0]    <= SERIAL_DO_I[3:0];
        PH_OE_O[3:0] <= SERIAL_OE_I[3:0];
      end
      if (route_ff[`ROUTE_SER2_BIT])
      begin
        PH_O[7:4]    <= SERIAL_DO_I[7:4];
        PH_OE_O[7:4] <= SERIAL_OE_I[7:4];
      end
      // [RQ15] Open-drain two-wire
      if (TWI_EN_I)
      begin
        PJ_O[`J_TWI_SDA]    <= 1'b0;
        PJ_OE_O[`J_TWI_SDA] <= TWI_SDA_LOW_I;
        PJ_O[`J_TWI_SCL]    <= 1'b0;
        PJ_OE_O[`J_TWI_SCL] <= TWI_SCL_LOW_I;
      end
    end
  end

  //--------------------------------------------------------------------
  // Expanded bus function select
  //--------------------------------------------------------------------
  // Bus function from the latched mode and the software select bit
  always_comb
  begin
    case (mode_ff)
      // [RQ14] Software choice
      pim_pkg::MODE_NORMAL_EXP:  nxt_bus_func = !route_ff[`ROUTE_EGPIO_BIT];
      pim_pkg::MODE_EMUL_EXP:    nxt_bus_func = 1'b1;
      pim_pkg::MODE_EMUL_SC:     nxt_bus_func = 1'b1;
      pim_pkg::MODE_SPECIAL_TST: nxt_bus_func = 1'b1;
      default:                   nxt_bus_func = 1'b0;
    endcase
    nxt_bus_func = nxt_bus_func && strap_done_ff;
  end

  // [RQ13] Time-multiplex phase
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      EBUS_FUNC_O <= 1'b0;
      EBUS_MUX_O  <= 1'b0;
    end
    else
    begin
      EBUS_FUNC_O <= nxt_bus_func;
      if (nxt_bus_func && (mode_ff == pim_pkg::MODE_EMUL_EXP ||
                           mode_ff == pim_pkg::MODE_EMUL_SC))
        EBUS_MUX_O <= !EBUS_MUX_O;
      else
        EBUS_MUX_O <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Register reads
  //--------------------------------------------------------------------
  // Read mux; data reads show pin level for inputs, latch for outputs
  always_comb
  begin
    nxt_rdata = 8'h00;
    for (int p = 0; p < 3; p++)
    begin
      if (RD_I && port_of(ADDR_I) == 2'(p))
      begin
        if (ADDR_I[2:0] == `REG_DATA)
          nxt_rdata = (dir_ff[8*p +: 8] & data_ff[8*p +: 8]) |
                      (~dir_ff[8*p +: 8] & sync2_ff[8*p +: 8]);
        else if (ADDR_I[2:0] == `REG_DIR)
          nxt_rdata = dir_ff[8*p +: 8];
        else if (ADDR_I[2:0] == `REG_POL)
          nxt_rdata = pol_ff[8*p +: 8];
        else if (ADDR_I[2:0] == `REG_IE)
          nxt_rdata = ie_ff[8*p +: 8];
        else
          nxt_rdata = if_ff[8*p +: 8];
      end
    end
    if (RD_I && ADDR_I == `ADDR_ROUTE)
      nxt_rdata = route_ff;
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
      RDATA_O <= 8'h00;
    else
      RDATA_O <= nxt_rdata;
  end

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  a_flag_sticky: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ17]
    (($past(if_ff) & ~$past(clr_if) & ~if_ff) == '0))
    else $error("Pin flag dropped without a software clear");

  a_flag_on_edge: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ17]
    ((fif.valid_edge & `PIN_MASK) != '0) |=> ((if_ff & $past(fif.valid_edge)) != '0))
    else $error("Filtered edge did not set its flag");

  a_port_request: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ4]
    (|(if_ff[15:8] & ie_ff[15:8])) |=> IRQ_H_O)
    else $error("Port H request missing with flag and enable set");

  a_port_quiet: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ2]
    IRQ_P_O |-> $past(|pending[7:0]))
    else $error("Port P request without a pending pin");

  a_wake_cpu: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ5]
    (STOP_I && |pending) |=> WAKE_O)
    else $error("Pending interrupt failed to wake the CPU");

  a_run_sampling: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ7]
    !STOP_I |-> fif.sample_en)
    else $error("Filter not sampled on bus clock outside stop");

  a_osc_gate: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ9]
    !(STOP_I && osc_need) |=> !RC_OSC_ON_O && rc_cnt_ff == '0)
    else $error("RC oscillator ran without demand");

  a_stop_tick: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ8]
    (STOP_I && fif.sample_en) |-> rc_tick_ff)
    else $error("Stop-mode sample outside an oscillator tick");

  a_twi_open_drain: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ15]
    TWI_EN_I |=> !PJ_O[`J_TWI_SDA] && !PJ_O[`J_TWI_SCL])
    else $error("Two-wire pin drove high");

  a_reset_inputs: assert property (@(posedge MCLK_I) // [RQ11]
    $fell(RST_I) |-> PP_OE_O == 8'h00 && PH_OE_O == 8'h00 && PJ_OE_O == 7'h00)
    else $error("Port not an input after reset");

endmodule // port_pin_irq_mux

`default_nettype wire

// [common/pim_defines.svh]
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// [RQ1] Every interrupt pin has its own enable and rising or falling choice.
// [RQ2] All pins of one port share that port's single interrupt request.
// [RQ3] Edges are detected whatever the pin's direction setting.
// [RQ4] Port request is high while any pin has flag and enable set.
// [RQ5] A pending enabled pin interrupt wakes the CPU from stop or wait.
// [RQ6] Valid edge needs four inactive samples, then four active samples.
// [RQ7] In run and wait the filters sample on every bus clock.
// [RQ8] In stop the filters sample on the internal RC oscillator ticks.
// [RQ9] In stop the oscillator runs only while some enabled unflagged pin is unsettled.
// [RQ10] Ports P, H and J interrupt: eight pins on H, seven on J.
// [RQ11] After reset the peripheral ports are general-purpose inputs.
// [RQ12] After reset the bus ports follow the sampled mode pins.
// [RQ13] Multiplexed bus pins alternate between their two functions each cycle; the code alternates only in MODE_EMUL_EXP and MODE_EMUL_SC.
// [RQ14] A software bit selects between alternative bus pin functions.
// [RQ15] When two-wire takes a port J pin, that pin drives open-drain.
// [RQ16] Routing control puts serial interfaces onto port H; otherwise GPIO.
// [RQ17] Flag sets on a filtered valid edge and holds until software clears.
`ifndef PIM_DEFINES_SVH
`define PIM_DEFINES_SVH

// Register selects inside a port slot (address bits 2:0)
`define REG_DATA        3'h0
`define REG_DIR         3'h1
`define REG_POL         3'h2
`define REG_IE          3'h3
`define REG_IF          3'h4
// Routing control register address and bits
`define ADDR_ROUTE      5'h18
`define ROUTE_SER1_BIT  0
`define ROUTE_SER2_BIT  1
`define ROUTE_EGPIO_BIT 2
// Reset values
`define RST_BYTE        8'h00
`define RST_PINS        24'h000000
// Port J has seven pins: top bit of the 24-pin vector is absent
`define PIN_MASK        24'h7FFFFF
// Two-wire pins inside port J
`define J_TWI_SDA       5
`define J_TWI_SCL       6
// Filter and oscillator timing
`define FILT_SAMPLES    4
`define RC_DIV          4

`endif

// [common/pim_pkg.sv]
package pim_pkg;

  // Operating mode as sampled from the mode pins
  typedef enum logic [2:0] {
    MODE_SPECIAL_SC  = 3'b000,
    MODE_EMUL_EXP    = 3'b001,
    MODE_SPECIAL_TST = 3'b010,
    MODE_EMUL_SC     = 3'b011,
    MODE_NORMAL_SC   = 3'b100,
    MODE_NORMAL_EXP  = 3'b101
  } mode_e;

  typedef logic [7:0] byte_t;

endpackage

// [common/pin_filter_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface pin_filter_if #(parameter int W = 24);
  logic         sample_en;
  logic [W-1:0] level;
  logic [W-1:0] rising;
  logic [W-1:0] valid_edge;
  logic [W-1:0] unsettled;

  modport ctrl (output sample_en, level, rising, input valid_edge, unsettled);
  modport filt (input sample_en, level, rising, output valid_edge, unsettled);
endinterface // pin_filter_if

`default_nettype wire

// [verilog/pin_edge_filter.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pim_defines.svh"

module pin_edge_filter #(
  parameter int W       = 24,
  parameter int SAMPLES = `FILT_SAMPLES
) (
  input wire logic   clk_i,
  input wire logic   rst_i,
  pin_filter_if.filt fif
);

  localparam int CW = $clog2(SAMPLES + 2);
  localparam logic [CW-1:0] SAT  = CW'(SAMPLES + 1);
  localparam logic [CW-1:0] FULL = CW'(SAMPLES);

  logic [CW-1:0] cnt_ff [W];
  logic [W-1:0]  act_ff;
  logic [W-1:0]  armed_ff;
  logic [W-1:0]  edge_ff;
  logic [W-1:0]  act;
  logic [W-1:0]  at_full;

  // Next run length of equal samples, saturating above the threshold
  function automatic logic [CW-1:0] nxt_run(input logic [CW-1:0] c, input logic same);
    if (!same)
      nxt_run = CW'(1);
    else if (c < SAT)
      nxt_run = c + CW'(1);
    else
      nxt_run = c;
  endfunction

  // Active level follows the chosen polarity
  assign act = ~(fif.level ^ fif.rising);

  // Run counting, arming on inactive runs, edge on active run
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < W; i++)
        cnt_ff[i] <= '0;
      act_ff   <= '0;
      armed_ff <= '0;
      edge_ff  <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        edge_ff[i] <= 1'b0;
        if (fif.sample_en)
        begin
          cnt_ff[i] <= nxt_run(cnt_ff[i], act[i] == act_ff[i]);
          act_ff[i] <= act[i];
          // [RQ6] Four inactive arm
          if (!act[i] && nxt_run(cnt_ff[i], act[i] == act_ff[i]) == FULL)
            armed_ff[i] <= 1'b1;
          // [RQ6] Four active fire
          else if (act[i] && armed_ff[i] && nxt_run(cnt_ff[i], act[i] == act_ff[i]) == FULL)
          begin
            armed_ff[i] <= 1'b0;
            edge_ff[i]  <= 1'b1;
          end
        end
      end
    end
  end

  // Status toward the port logic
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      at_full[i]       = (cnt_ff[i] == FULL);
      // A fresh level change counts as unsettled so stop mode can restart sampling
      fif.unsettled[i] = (cnt_ff[i] <= FULL) || (act[i] != act_ff[i]);
    end
  end
  assign fif.valid_edge = edge_ff;

  a_edge_needs_arm: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (edge_ff & ~$past(armed_ff)) == '0)
    else $error("Edge raised without four inactive samples first");

  a_edge_four_run: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (edge_ff & ~(at_full & act_ff)) == '0)
    else $error("Edge raised without exactly four active samples");

endmodule // pin_edge_filter

`default_nettype wire

// [testbench/pin_world.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Pin side model
// ----------------------------------------------------------------
module pin_world (
  input  wire logic [22:0] ext_i,
  input  wire logic [22:0] o_i,
  input  wire logic [22:0] oe_i,
  output var  logic [22:0] pin_o
);
  // Pins the device drives follow it, the rest follow the outside world
  assign pin_o = (oe_i & o_i) | (~oe_i & ext_i);
endmodule // pin_world

`default_nettype wire

// [testbench/port_pin_irq_mux_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pim_defines.svh"

module port_pin_irq_mux_test;
  logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        stop = 1'b0, wt = 1'b0, twi_en = 1'b0, sda_low = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, sdo = 8'h00, soe = 8'h00, rdv, rv, rdata;
  logic [2:0]  mode = 3'h1;
  logic [22:0] ext = 23'h000000, pins;
  logic [7:0]  pp_o, pp_oe, ph_o, ph_oe;
  logic [6:0]  pj_o, pj_oe;
  logic        irq_p, irq_h, irq_j, irq, wake, rc_on, ebus_f, ebus_m, m0;
  int          n_fail = 0, checks_done = 0, cyc = 0, seed = 20, k;

  // Bus clock, 50 ns period
  always #25 mclk = ~mclk;

  port_pin_irq_mux #(.RC_DIV(4), .SAMPLES(4)) DUT (
    .MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .PP_I(pins[7:0]), .PH_I(pins[15:8]),
    .PJ_I(pins[22:16]), .PP_O(pp_o), .PP_OE_O(pp_oe), .PH_O(ph_o),
    .PH_OE_O(ph_oe), .PJ_O(pj_o), .PJ_OE_O(pj_oe), .SERIAL_DO_I(sdo),
    .SERIAL_OE_I(soe), .TWI_EN_I(twi_en), .TWI_SDA_LOW_I(sda_low),
    .TWI_SCL_LOW_I(1'b0), .STOP_I(stop), .WAIT_I(wt), .MODE_I(mode),
    .IRQ_P_O(irq_p), .IRQ_H_O(irq_h), .IRQ_J_O(irq_j), .IRQ_O(irq),
    .WAKE_O(wake), .RC_OSC_ON_O(rc_on), .EBUS_FUNC_O(ebus_f),
    .EBUS_MUX_O(ebus_m));

  pin_world world (.ext_i(ext), .o_i({pj_o, ph_o, pp_o}),
    .oe_i({pj_oe, ph_oe, pp_oe}), .pin_o(pins));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [4:0] ra(input int p, input logic [2:0] r);
    return {p[1:0], r};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic expect_reg(input logic [4:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rdv = rdata;
    chk(rdv, e);
  endtask

  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge mclk);
    rst <= 1'b1;
    mode <= m;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    step(6);
  endtask

  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc >= 6000)
    begin
      n_fail++;
      $display("[ERR] %0t run too long", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset(3'h1);
    chkb(ebus_f, 1'b1);
    m0 = ebus_m;
    step(1);
    chkb(ebus_m, ~m0);
    do_reset(3'h4);
    chkb(ebus_f, 1'b0);
    // Reset defaults and random config read-back
    for (int p = 0; p < 3; p++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        int r;
        r = (i + 3) % 4 + 1;
        expect_reg(ra(p, r), 8'h00);
        rv = $random(seed);
        if (p == 2) rv[7] = 1'b0;
        if (r < 4) wr_reg(ra(p, r), rv);
        if (r < 4) expect_reg(ra(p, r), rv);
        if (r < 4) wr_reg(ra(p, r), 8'h00);
      end
      // Polarity toggles above may have made real edges
      wr_reg(ra(p, `REG_IF), 8'hFF);
    end
    chk(ph_oe, 8'h00);
    chk(pp_oe, 8'h00);
    expect_reg(5'h1F, 8'h00);
    // Glitch of three samples, then a valid rising edge on port H
    k = $unsigned($random(seed)) % 8;
    wr_reg(ra(1, `REG_POL), 8'h01 << k);
    wr_reg(ra(1, `REG_IE), 8'h01 << k);
    @(posedge mclk) ext[8+k] <= 1'b1;
    repeat (3) @(posedge mclk);
    ext[8+k] <= 1'b0;
    step(20);
    chkb(irq_h, 1'b0);
    @(posedge mclk) ext[8+k] <= 1'b1;
    repeat (4) @(posedge mclk);
    ext[8+k] <= 1'b0;
    wait_irq(20);
    chkb(irq_h, 1'b1);
    chkb(irq_p, 1'b0);
    step(10);
    expect_reg(ra(1, `REG_IF), 8'h01 << k);
    wt <= 1'b1;
    step(3);
    chkb(wake, 1'b1);
    wt <= 1'b0;
    wr_reg(ra(1, `REG_IF), 8'h01 << k);
    step(3);
    chkb(irq, 1'b0);
    // Falling edge on port P pin 0
    wr_reg(ra(0, `REG_IE), 8'h01);
    @(posedge mclk) ext[0] <= 1'b1;
    step(12);
    chkb(irq, 1'b0);
    ext[0] <= 1'b0;
    wait_irq(20);
    chkb(irq_p, 1'b1);
    wr_reg(ra(0, `REG_IE), 8'h00);
    wr_reg(ra(0, `REG_IF), 8'h01);
    // Port J pin driven as output, enable off, then on
    wr_reg(ra(2, `REG_DIR), 8'h01);
    wr_reg(ra(2, `REG_POL), 8'h01);
    wr_reg(ra(2, `REG_DATA), 8'h01);
    step(20);
    chkb(irq_j, 1'b0);
    expect_reg(ra(2, `REG_IF), 8'h01);
    wr_reg(ra(2, `REG_IE), 8'h01);
    step(3);
    chkb(irq_j, 1'b1);
    wr_reg(ra(2, `REG_IE), 8'h00);
    wr_reg(ra(2, `REG_DIR), 8'h00);
    wr_reg(ra(2, `REG_IF), 8'h01);
    // Stop mode: oscillator only while an enabled pin is unsettled
    stop <= 1'b1;
    step(4);
    chkb(rc_on, 1'b0);
    ext[8+k] <= 1'b1;
    step(5);
    chkb(rc_on, 1'b1);
    wait_irq(200);
    chkb(wake, 1'b1);
    step(2);
    chkb(rc_on, 1'b0);
    stop <= 1'b0;
    wr_reg(ra(1, `REG_IE), 8'h00);
    // Two-wire open-drain on J5
    twi_en <= 1'b1;
    sda_low <= 1'b1;
    step(3);
    chkb(pj_oe[5], 1'b1);
    chkb(pj_o[5], 1'b0);
    sda_low <= 1'b0;
    step(3);
    chkb(pj_oe[5], 1'b0);
    twi_en <= 1'b0;
    // Serial one routed onto port H low nibble
    sdo <= $random(seed);
    soe <= 8'hFF;
    wr_reg(`ADDR_ROUTE, 8'h01);
    step(3);
    chk({4'h0, ph_o[3:0]}, {4'h0, sdo[3:0]});
    chk({4'h0, ph_oe[3:0]}, 8'h0F);
    wr_reg(`ADDR_ROUTE, 8'h00);
    step(3);
    chk(ph_oe, 8'h00);
    // Normal expanded: bus pins handed back to GPIO by software
    do_reset(3'h5);
    chkb(ebus_f, 1'b1);
    wr_reg(`ADDR_ROUTE, 8'h04);
    step(3);
    chkb(ebus_f, 1'b0);
    give_verdict();
  end
endmodule // port_pin_irq_mux_test

`default_nettype wire
